/* pkg/selector_defines.vh */
// Constants for the power source selector logic: timing counts and reset levels.
// Assumes a 125 MHz mclk and comparator results delivered as logic levels.
// Functional notes
// - Adapter absent: sleep, PWM off, battery on
// - Select high, adapter present: adapter switch on
// - Adapter-present flag follows adapter detect
// - Alarm while depletion sense below threshold
// - Fallback variant: alarm on selector mismatch
// - Flag no battery from dedicated comparator
// - Fallback: no battery selects adapter, PWM allowed
// - Select high, adapter present: battery switch off
// - Reference override above 0.25 V wins
// - Charge enable low: PWM off, gate high
// - PWM only with present, select or fallback, enable
// - Rail above battery feedback: battery off
// - Battery switch on only after adapter off
// - Adapter insertion deglitched about 100 us
// - Zero-volt mode: PWM off, pass on
`ifndef SELECTOR_DEFINES_VH
`define SELECTOR_DEFINES_VH

// ==========================================================
// Timing
// ==========================================================
`define CLK_PERIOD_PS      8000
`define DEGLITCH_TIME_US   100
`define DEGLITCH_CYCLES    ((`DEGLITCH_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define DEGLITCH_W         14

// ==========================================================
// Reset levels (drives are active low: high = switch off)
// ==========================================================
`define RST_ADAPTER_DRIVE  1'b1
`define RST_BATTERY_DRIVE  1'b0
`define RST_PWM_GATE       1'b1

// ==========================================================
// Interrupt status bit positions
// ==========================================================
`define EV_ADAPTER_IN      0
`define EV_ADAPTER_OUT     1
`define EV_DEPLETED        2
`define EV_NO_BATTERY      3
`define EV_W               4
`endif

/* hw/sync2.v */
// Two flip-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to mclk.
`timescale 1ns/1ps
module sync2
(
    mclk,
    srst,
    async_in,
    sync_out
);
    input  wire mclk;      // System clock
    input  wire srst;      // Synchronous reset
    input  wire async_in;  // Pin level
    output reg  sync_out;  // Level safe for logic

    reg stage1_reg;        // Read only by the second stage

    // ==========================================================
    // Synchroniser stages
    // ==========================================================
    // Metastability guard: stage1 feeds nothing else
    always @(posedge mclk)
    begin
        if (srst)
        begin
            stage1_reg <= 1'b0;
            sync_out   <= 1'b0;
        end
        else
        begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end
endmodule // sync2

/* hw/power_selector.v */
// Selection logic: power source switches, PWM gating, flags, event register.
// Assumes comparator outputs arrive asynchronously as clean logic levels.
`timescale 1ns/1ps
`include "selector_defines.vh"
module power_selector
(
    mclk,
    srst,
    adapter_detect_in,
    depletion_cmp_in,
    no_battery_cmp_in,
    zero_volt_cmp_in,
    source_select_in,
    charge_enable_in,
    system_rail_sense,
    ref_override_cmp_in,
    fallback_variant,
    pwm_request_in,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    adapter_switch_drive,
    battery_switch_drive,
    adapter_present_flag,
    alarm_out,
    pwm_enable,
    pwm_gate,
    sleep_mode,
    zero_volt_pass_on,
    use_external_ref,
    no_battery_flag,
    irq
);
    input  wire       mclk;                 // 125 MHz system clock
    input  wire       srst;                 // Synchronous reset, high
    input  wire       adapter_detect_in;    // Adapter detect above threshold
    input  wire       depletion_cmp_in;     // High: depletion_sense below trip
    input  wire       no_battery_cmp_in;    // High: battery below 80 % of trip
    input  wire       zero_volt_cmp_in;     // High: below zero-volt threshold
    input  wire       source_select_in;     // High adapter, low battery
    input  wire       charge_enable_in;     // Charge enable pin
    input  wire       system_rail_sense;    // High: rail above battery feedback
    input  wire       ref_override_cmp_in;  // High: voltage_ref_override > 0.25 V
    input  wire       fallback_variant;     // Tie high for auto fallback part
    input  wire       pwm_request_in;       // Raw modulator output, high = on
    input  wire [1:0] reg_addr;             // Register index
    input  wire [7:0] reg_wdata;            // Write data
    input  wire       reg_wr;               // Write strobe
    input  wire       reg_rd;               // Read strobe
    output reg  [7:0] reg_rdata;            // Read data, cycle after strobe
    output reg        adapter_switch_drive; // Low = adapter switch on
    output reg        battery_switch_drive; // Low = battery switch on
    output reg        adapter_present_flag; // Valid adapter power
    output reg        alarm_out;            // Depleted or mismatch
    output reg        pwm_enable;           // Modulator allowed to run
    output reg        pwm_gate;             // Gate drive, high = off
    output reg        sleep_mode;           // Low power state
    output reg        zero_volt_pass_on;    // Pass switch on
    output reg        use_external_ref;     // Select override reference
    output reg        no_battery_flag;      // Battery missing
    output reg        irq;                  // Level interrupt

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    wire det_s;     // Adapter detect
    wire dep_s;     // Depleted
    wire nob_s;     // No battery
    wire zv_s;      // Zero volt
    wire sel_s;     // Source select
    wire en_s;      // Charge enable
    wire rail_s;    // Rail above battery
    wire ref_s;     // Override above 0.25 V
    wire fb_s;      // Variant strap
    wire pwmr_s;    // Modulator request

    wire [9:0] raw_in;
    wire [9:0] syn_in;
    assign raw_in = {pwm_request_in, fallback_variant, ref_override_cmp_in,
                     system_rail_sense, charge_enable_in, source_select_in,
                     zero_volt_cmp_in, no_battery_cmp_in, depletion_cmp_in,
                     adapter_detect_in};
    assign {pwmr_s, fb_s, ref_s, rail_s, en_s, sel_s, zv_s, nob_s, dep_s, det_s}
        = syn_in;

    // All pins pass two stages before use
    // Straps go through too; it only costs two cycles of latency
    // Reset clears every stage, so all pins read low at first
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi = gi + 1)
        begin : g_sync
            sync2 u_sync
            (
                .mclk     (mclk),
                .srst     (srst),
                .async_in (raw_in[gi]),
                .sync_out (syn_in[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Insertion deglitch
    // ==========================================================
    localparam integer DEG_CYCLES_I = `DEGLITCH_CYCLES;  // 100 us of mclk
    // Sliced on purpose: the count fits the counter width
    localparam [`DEGLITCH_W-1:0] DEG_MAX = DEG_CYCLES_I[`DEGLITCH_W-1:0];
    reg [`DEGLITCH_W-1:0] deg_cnt_reg;  // Stable-high counter
    reg                   present_reg;  // Deglitched presence

    // Insertion must hold ~100 us; loss acts at once
    always @(posedge mclk)
    begin
        if (srst)
        begin
            deg_cnt_reg <= {`DEGLITCH_W{1'b0}};
            present_reg <= 1'b0;
        end
        else if (!det_s)
        begin
            // Loss is never delayed, so sleep is prompt
            deg_cnt_reg <= {`DEGLITCH_W{1'b0}};
            present_reg <= 1'b0;
        end
        else if (deg_cnt_reg == DEG_MAX - 1'b1)
        begin
            // Counter parks here while detect holds
            present_reg <= 1'b1;
        end
        else
        begin
            deg_cnt_reg <= deg_cnt_reg + 1'b1;
        end
    end

    // ==========================================================
    // Source selection state machine
    // ==========================================================
    localparam [1:0] ST_BAT      = 2'd0;  // Battery feeding system
    localparam [1:0] ST_TO_AC    = 2'd1;  // Battery off, adapter pending
    localparam [1:0] ST_AC       = 2'd2;  // Adapter feeding system
    localparam [1:0] ST_TO_BAT   = 2'd3;  // Adapter off, waiting on rail

    reg  [1:0] state_reg;
    reg  [1:0] state_next;
    wire       want_ac;     // Adapter should feed system
    wire       fallback_ac; // No-battery forced adapter

    assign fallback_ac = fb_s & nob_s & present_reg;
    assign want_ac = present_reg & (sel_s | fallback_ac);

    // Next state; break before make both ways
    // Limitation: a rail sense tied low skips the wait, so the
    // switches then rely on the two-cycle gap alone
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_BAT:
                if (want_ac)
                    state_next = ST_TO_AC;
            ST_TO_AC:
                // Battery now off; adapter may close
                state_next = want_ac ? ST_AC : ST_BAT;
            ST_AC:
                if (!want_ac)
                    state_next = ST_TO_BAT;
            ST_TO_BAT:
                // Hold battery off until rail falls below battery
                if (want_ac)
                    state_next = ST_AC;
                else if (!rail_s || !present_reg)
                    state_next = ST_BAT;
            default:
                state_next = ST_BAT;
        endcase
    end

    // State register
    always @(posedge mclk)
    begin
        if (srst)
            state_reg <= ST_BAT;
        else
            state_reg <= state_next;
    end

    // ==========================================================
    // Output decode
    // ==========================================================
    wire pwm_ok;   // PWM conditions met
    wire zv_mode;  // Zero-volt mode

    // Zero-volt compare gated by enable, select and presence; it sits below the depletion trip
    assign zv_mode = zv_s & en_s & sel_s & present_reg;
    // Fallback keeps the modulator allowed while enable is high
    assign pwm_ok  = want_ac & en_s & !zv_mode;

    // Registered drives keep outputs glitch free
    always @(posedge mclk)
    begin
        if (srst)
        begin
            // Battery selected, PWM off
            adapter_switch_drive <= `RST_ADAPTER_DRIVE;
            battery_switch_drive <= `RST_BATTERY_DRIVE;
            adapter_present_flag <= 1'b0;
            alarm_out            <= 1'b0;
            pwm_enable           <= 1'b0;
            pwm_gate             <= `RST_PWM_GATE;
            sleep_mode           <= 1'b1;
            zero_volt_pass_on    <= 1'b0;
            use_external_ref     <= 1'b0;
            no_battery_flag      <= 1'b0;
        end
        else
        begin
            sleep_mode           <= !present_reg;
            adapter_present_flag <= present_reg;
            // Adapter on only in ST_AC
            // Opens in the cycle presence or select drops, not one later
            adapter_switch_drive <= !((state_reg == ST_AC) & want_ac);
            // Battery off when adapter path or rail high
            battery_switch_drive <= (state_reg != ST_BAT) | rail_s;
            // Mismatch only counts on fallback part
            alarm_out            <= dep_s | (fb_s & (sel_s != want_ac));
            no_battery_flag      <= nob_s;
            use_external_ref     <= ref_s;
            zero_volt_pass_on    <= zv_mode;
            pwm_enable           <= pwm_ok;
            // Gate held high whenever disabled
            pwm_gate             <= !(pwm_ok & pwmr_s);
        end
    end

    // ==========================================================
    // Event status, mask and interrupt
    // ==========================================================
    // Register map:
    //   0 status, write one to clear: 0 adapter in, 1 adapter out,
    //     2 depletion rise, 3 no-battery rise
    //   1 mask, same layout; irq is a flop so it lags status by a cycle
    //   2 live levels, read only; 3 reads zero, writes are dropped
    localparam [1:0] A_STATUS = 2'd0;  // W1C sticky events
    localparam [1:0] A_MASK   = 2'd1;  // Interrupt enables
    localparam [1:0] A_LIVE   = 2'd2;  // Live levels, read only

    reg  [`EV_W-1:0] status_reg;
    reg  [`EV_W-1:0] mask_reg;
    reg              pres_d_reg;  // For edges
    reg              dep_d_reg;
    reg              nob_d_reg;
    wire [`EV_W-1:0] ev;
    wire [7:0]       live;

    assign ev[`EV_ADAPTER_IN]  = present_reg & !pres_d_reg;
    assign ev[`EV_ADAPTER_OUT] = !present_reg & pres_d_reg;
    assign ev[`EV_DEPLETED]    = dep_s & !dep_d_reg;
    assign ev[`EV_NO_BATTERY]  = nob_s & !nob_d_reg;
    assign live = {1'b0, zv_mode, fallback_ac, nob_s, dep_s, present_reg, state_reg};

    // Set beats a same-cycle clear
    always @(posedge mclk)
    begin
        if (srst)
        begin
            status_reg <= {`EV_W{1'b0}};
            mask_reg   <= {`EV_W{1'b0}};
            pres_d_reg <= 1'b0;
            dep_d_reg  <= 1'b0;
            nob_d_reg  <= 1'b0;
            irq        <= 1'b0;
            reg_rdata  <= 8'h00;
        end
        else
        begin
            pres_d_reg <= present_reg;
            dep_d_reg  <= dep_s;
            nob_d_reg  <= nob_s;
            if (reg_wr && reg_addr == A_STATUS)
                status_reg <= (status_reg & ~reg_wdata[`EV_W-1:0]) | ev;
            else
                status_reg <= status_reg | ev;
            if (reg_wr && reg_addr == A_MASK)
                mask_reg <= reg_wdata[`EV_W-1:0];
            irq <= |(status_reg & mask_reg);
            // Read data valid only the cycle after the strobe
            if (reg_rd)
                case (reg_addr)
                    A_STATUS: reg_rdata <= {4'h0, status_reg};
                    A_MASK:   reg_rdata <= {4'h0, mask_reg};
                    A_LIVE:   reg_rdata <= live;
                    default:  reg_rdata <= 8'h00;
                endcase
            else
                reg_rdata <= 8'h00;
        end
    end
endmodule // power_selector

/* verif/power_switches.sv */
// Partner model: external adapter switch and the system rail it feeds.
// Assumes drives are active low; the rail holds up for a while after the adapter opens.
`timescale 1ns/1ps
module power_switches
(
    input  wire mclk,                        // System clock
    input  wire adapter_switch_drive,        // Low = adapter switch closed
    input  wire slow,                        // High = long rail hold-up
    output reg  system_rail_sense = 1'b0     // High = rail above battery feedback
);
    reg [5:0] decay = 6'h00;                 // Hold-up cycles left
    // ==========================================================
    // Rail decay
    // ==========================================================
    // Bulk capacitance keeps the rail up, so the battery must wait for it
    always @(posedge mclk)
        if (!adapter_switch_drive)
        begin
            decay             <= slow ? 6'h1e : 6'h03;
            system_rail_sense <= 1'b1;
        end
        else if (decay != 6'h00)
            decay <= decay - 6'h01;
        else
            system_rail_sense <= 1'b0;
endmodule // power_switches

/* verif/power_selector_asserts.sv */
// Checker for the selector outputs, bound to power_selector.
// Assumes one mclk domain and srst high for reset.
`timescale 1ns/1ps
module power_selector_asserts
(
    input wire       mclk,
    input wire       srst,
    input wire       adapter_detect_in,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       adapter_switch_drive,
    input wire       battery_switch_drive,
    input wire       adapter_present_flag,
    input wire       pwm_enable,
    input wire       pwm_gate,
    input wire       sleep_mode,
    input wire       zero_volt_pass_on
);
    reg [13:0] hi_cnt = 14'h0000;            // Cycles detect has stayed high
    // Saturating, so a long-present adapter never wraps
    always @(posedge mclk)
        if (srst || !adapter_detect_in)
            hi_cnt <= 14'h0000;
        else if (hi_cnt != 14'h3fff)
            hi_cnt <= hi_cnt + 14'h0001;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // ==========================================================
    // Properties
    // ==========================================================
    AST_ABSENT_AC_OFF: assert property (!adapter_present_flag |-> adapter_switch_drive)
        else $error("adapter switch on without adapter");
    AST_SLEEP: assert property (sleep_mode == !adapter_present_flag)
        else $error("sleep disagrees with presence");
    AST_PWM_NEEDS_AC: assert property (pwm_enable |-> adapter_present_flag)
        else $error("pwm on without adapter");
    AST_GATE_OFF: assert property (!pwm_enable |-> pwm_gate)
        else $error("gate driven while pwm disabled");
    AST_NO_OVERLAP: assert property (!adapter_switch_drive |-> battery_switch_drive)
        else $error("both switches on");
    AST_BREAK_FIRST: assert property ($fell(battery_switch_drive) |->
        $past(adapter_switch_drive, 2))
        else $error("battery on before adapter off");
    AST_DEGLITCH: assert property ($rose(adapter_present_flag) |-> hi_cnt >= 14'd12400)
        else $error("adapter declared too early");
    AST_ZV_PWM: assert property (zero_volt_pass_on |-> !pwm_enable)
        else $error("pwm on in zero volt mode");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    COV_PRESENT: cover property ($rose(adapter_present_flag));
    COV_TO_BAT: cover property ($fell(battery_switch_drive));
    COV_ZV: cover property (zero_volt_pass_on);
endmodule // power_selector_asserts

bind power_selector power_selector_asserts u_chk
(
    .mclk(mclk), .srst(srst), .adapter_detect_in(adapter_detect_in),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adapter_switch_drive(adapter_switch_drive),
    .battery_switch_drive(battery_switch_drive), .adapter_present_flag(adapter_present_flag),
    .pwm_enable(pwm_enable), .pwm_gate(pwm_gate), .sleep_mode(sleep_mode),
    .zero_volt_pass_on(zero_volt_pass_on)
);

/* verif/test_power_selector.sv */
// Self-checking bench for power_selector against a small output model.
// Assumes power_switches closes the rail loop; deglitch stays at its full count.
`timescale 1ns/1ps
module test_power_selector;
    reg        mclk, srst;                                  // Clock, reset
    reg        det, dep, nob, zv, sel, en, ovr, fb, preq, slow; // Pin levels
    reg  [1:0] addr;                                        // Register index
    reg  [7:0] wdata, v;                                    // Write data, read result
    reg        wr, rd;                                      // Strobes
    wire [7:0] rdata;                                       // Read data
    wire       ad, bd, pres, alarm, pwm, gate, slp, pass, xref, nobf, irq, rail;
    integer    num_errors, n_tests, cyc, i, m_pres;         // Counters, model state
    power_selector u_dut
    (
        .mclk(mclk), .srst(srst), .adapter_detect_in(det), .depletion_cmp_in(dep),
        .no_battery_cmp_in(nob), .zero_volt_cmp_in(zv), .source_select_in(sel),
        .charge_enable_in(en), .system_rail_sense(rail), .ref_override_cmp_in(ovr),
        .fallback_variant(fb), .pwm_request_in(preq), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .adapter_switch_drive(ad),
        .battery_switch_drive(bd), .adapter_present_flag(pres), .alarm_out(alarm),
        .pwm_enable(pwm), .pwm_gate(gate), .sleep_mode(slp), .zero_volt_pass_on(pass),
        .use_external_ref(xref), .no_battery_flag(nobf), .irq(irq)
    );
    power_switches u_sw
    (
        .mclk(mclk), .adapter_switch_drive(ad), .slow(slow), .system_rail_sense(rail)
    );
    // ==========================================================
    // Tasks
    // ==========================================================
    task chk(input [8*8:1] nm, input [7:0] e, input [7:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e)
            begin
                num_errors = num_errors + 1;
                $display("wrong value %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d errors %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task wr_reg(input [1:0] a, input [7:0] d);
        begin
            @(posedge mclk);
            addr <= a; wdata <= d; wr <= 1'b1;
            @(posedge mclk);
            wr <= 1'b0;
        end
    endtask
    // Data stand only in the cycle after the strobe, so sample just past that edge
    task rd_reg(input [1:0] a);
        begin
            @(posedge mclk);
            addr <= a; rd <= 1'b1;
            @(posedge mclk);
            rd <= 1'b0;
            #1 v = rdata;
        end
    endtask
    // Long enough for sync, output flop and the slow rail hold-up
    task settle;
        begin
            repeat (40) @(posedge mclk);
            #1;
        end
    endtask
    // Model of steady outputs from pin levels and the presence state
    task check_outs;
        integer on_ac, zvm, pwm_e;
        begin
            on_ac = m_pres && (sel || (fb && nob));
            zvm = m_pres && zv && en && sel;
            pwm_e = on_ac && en && !zvm;
            chk("ac_drv", !on_ac, ad);
            chk("bat_drv", on_ac, bd);
            chk("pwm", pwm_e, pwm);
            chk("gate", !(pwm_e && preq), gate);
            chk("present", m_pres, pres);
            chk("sleep", !m_pres, slp);
            chk("alarm", dep || (fb && (sel != on_ac)), alarm);
            chk("no_bat", nob, nobf);
            chk("ext_ref", ovr, xref);
            chk("zv_pass", zvm, pass);
        end
    endtask
    // ==========================================================
    // Clock, timeout, sequence
    // ==========================================================
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc = cyc + 1;
        if (cyc == 30000)
        begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    initial
    begin
        {det, dep, nob, zv, sel, en, ovr, fb, preq, slow, wr, rd} = 12'h000;
        addr = 2'h0; wdata = 8'h00; v = 8'h00;
        srst = 1'b1; num_errors = 0; n_tests = 0; cyc = 0; m_pres = 0;
        void'($urandom(32'hcc23));
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        sel <= 1'b1; en <= 1'b1;
        settle;
        check_outs;
        wr_reg(2'h0, 8'hff);
        det <= 1'b1;
        repeat (1000) @(posedge mclk);
        det <= 1'b0;
        settle;
        check_outs;
        @(posedge mclk);
        det <= 1'b1;
        i = 0;
        while (pres !== 1'b1 && i < 13000)
        begin
            @(posedge mclk);
            i = i + 1;
        end
        chk("deglitch", 8'h1, {7'h0, i >= 12400 && i < 13000});
        m_pres = 1;
        settle;
        check_outs;
        rd_reg(2'h0);
        chk("status", 8'h01, v);
        rd_reg(2'h2);
        chk("live", 8'h06, v);
        wr_reg(2'h3, 8'hff);
        rd_reg(2'h3);
        chk("unmapped", 8'h00, v);
        rd_reg(2'h1);
        chk("mask", 8'h00, v);
        chk("irq_off", 8'h0, irq);
        wr_reg(2'h1, 8'h01);
        settle;
        chk("irq_on", 8'h1, irq);
        wr_reg(2'h0, 8'h01);
        settle;
        chk("irq_clr", 8'h0, irq);
        // Walk every combination of select, enable, depletion, zero volt, fallback
        for (i = 0; i < 32; i = i + 1)
        begin
            @(posedge mclk);
            {sel, en, dep, zv, fb} <= i[4:0];
            nob <= $urandom % 2;
            ovr <= $urandom % 2;
            preq <= $urandom % 2;
            slow <= $urandom % 2;
            settle;
            check_outs;
        end
        @(posedge mclk);
        sel <= 1'b1;
        settle;
        @(posedge mclk);
        det <= 1'b0;
        m_pres = 0;
        settle;
        check_outs;
        rd_reg(2'h0);
        chk("ac_out", 8'h2, v & 8'h02);
        test_done;
    end
endmodule // test_power_selector
